// File: logic/vfdsc_pkg.sv
// Package of constants for the fluorescent display scan controller.
package vfdsc_pkg;
  // Register byte offsets on the bus.
  localparam logic [7:0] ADDR_DIGIT_CTRL = 8'h00;
  localparam logic [7:0] ADDR_SEG_CTRL = 8'h04;
  localparam logic [7:0] ADDR_DIGIT_START = 8'h08;
  localparam logic [7:0] ADDR_IRQ_REQ = 8'h0C;
  localparam logic [7:0] ADDR_IRQ_EN = 8'h10;
  localparam logic [7:0] ADDR_GP_OUT = 8'h14;
  localparam logic [7:0] ADDR_STATUS = 8'h18;
  // Display RAM window: byte offsets 0x100..0x13F mirror H'FEC0..H'FEFF.
  localparam logic [8:0] ADDR_RAM_BASE = 9'h100;
  localparam logic [15:0] RAM_CPU_BASE = 16'hFEC0;
  localparam int RAM_WORDS = 16;
  // Digit control field positions.
  localparam int DC_RANGE_LSB = 0;
  localparam int DC_WAVE_LSB = 4;
  localparam int DC_SCANT_BIT = 7;
  // Segment control field positions.
  localparam int SC_RANGE_LSB = 0;
  localparam int SC_KEYSCAN_BIT = 5;
  localparam int SC_VALID_BIT = 7;
  // Digit start register fields and reset value.
  localparam int DS_DISPLAY_ON_BIT = 6;
  localparam int DS_RUN_BIT = 7;
  localparam logic [7:0] DS_RESET = 8'h20;
  localparam logic [7:0] DS_WMASK = 8'hDF;
  localparam logic [4:0] SEG_ALL = 5'h1B;
  // Slot lengths in clocks, for short and long scan time.
  localparam int SLOT_SHORT_CYC = 256;
  localparam int SLOT_LONG_CYC = 512;
  localparam int SHARED_PINS = 8;
endpackage : vfdsc_pkg

// File: logic/vfdsc_ram.sv
// Display RAM: sixteen words, one per digit, with a registered scan port.
`timescale 1ns/1ns
module vfdsc_ram #(
  parameter int WORDS = 16
) (
  input wire logic clk,
  input wire logic we,
  input wire logic [3:0] waddr,
  input wire logic [31:0] wdata,
  input wire logic [3:0] raddr,
  output logic [31:0] rdata,
  input wire logic [3:0] saddr,
  output logic [31:0] sdata
);
  logic [31:0] mem [WORDS];

  // Write port plus two registered read ports, one for bus and one for scan.
  always_ff @(posedge clk)
  begin
    if (we)
    begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
    sdata <= mem[saddr];
  end
endmodule : vfdsc_ram

// File: logic/vfdsc_top.sv
// Scan controller for a fluorescent display with AHB-Lite register access.
//
// Function
// - 28 segment, 16 digit outputs, 8 shared.
// - Digit start field picks shared pin roles.
// - Frame timing from enabled digit count.
// - Key scan adds slot; pins become ports.
// - Digit outputs low through key scan.
// - Patterns fetched from display RAM window.
// - Four bytes per digit, byte order fixed.
// - Unused display RAM is plain RAM.
// - Digit range zero enables all sixteen.
// - Pin valid enables pins; key scan bit.
// - Segment range 11011 enables all 28.
// - Start 0011: digit 3, segment 5 first.
// - Display on and controller run bits.
// - Scan time bit; waveform select field.
// - Key scan slot start sets request flag.
// - Request forwarded only when enabled.
// - Control register write restarts scan.
// - Display off blanks segments, digits scan.
// - Run bit clear holds controller reset.
// - Start field sets shared digit count.
`timescale 1ns/1ns
module vfdsc_top
  import vfdsc_pkg::*;
#(
  parameter int SLOT_SHORT = SLOT_SHORT_CYC,
  parameter int SLOT_LONG = SLOT_LONG_CYC
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic [27:0] segment_pin,
  output logic [15:0] digit_pin,
  output logic [27:0] segment_gp_oe,
  output logic [15:0] digit_gp_oe,
  output logic keyscan_irq
);
  logic [7:0] digit_control_reg_q;
  logic [7:0] segment_control_reg_q;
  logic [7:0] digit_start_reg_q;
  logic keyscan_irq_flag_q;
  logic keyscan_irq_enable_q;
  logic [43:0] gp_out_q;
  logic wr_pend_q;
  logic rd_pend_q;
  logic [8:0] addr_q;
  logic [31:0] ram_rdata;
  logic [31:0] scan_word;
  logic [3:0] digit_q;
  logic key_slot_q;
  logic [9:0] slot_cnt_q;
  logic scan_restart;
  logic run;
  logic slot_end;
  logic [3:0] last_digit;
  logic [3:0] first_digit;
  logic [4:0] last_seg;
  logic [3:0] show_digit_q;
  logic show_key_q;
  logic fwd_q;
  logic [31:0] fwd_data_q;
  logic [9:0] slot_len;
  logic ram_we;
  logic [27:0] seg_en;
  logic [15:0] dig_en;
  logic addr_phase;

  assign addr_phase = hsel && hready && htrans[1];
  // Bus writes land in the data phase, so the write strobe uses the latched
  // address and current hwdata.
  assign ram_we = wr_pend_q && addr_q[8];

  // Address phase capture for the data phase that follows it.
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      addr_q <= 9'h000;
    end
    else
    begin
      wr_pend_q <= addr_phase && hwrite;
      rd_pend_q <= addr_phase && !hwrite;
      if (addr_phase)
      begin
        addr_q <= haddr[8:0];
      end
    end
  end

  // Reads take one wait state so that hrdata can leave a register while the
  // master samples it; writes complete with no wait. The answer is OKAY.
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
    else
    begin
      hreadyout <= !(addr_phase && !hwrite);
      hresp <= 1'b0;
    end
  end

  // Control registers; the reserved bit of the start register reads one.
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      digit_control_reg_q <= 8'h00;
      segment_control_reg_q <= 8'h00;
      digit_start_reg_q <= DS_RESET;
      keyscan_irq_enable_q <= 1'b0;
      gp_out_q <= '0;
    end
    else if (wr_pend_q && !addr_q[8])
    begin
      unique case (addr_q[7:0])
        ADDR_DIGIT_CTRL: digit_control_reg_q <= hwdata[7:0];
        ADDR_SEG_CTRL: segment_control_reg_q <= hwdata[7:0];
        ADDR_DIGIT_START:
          digit_start_reg_q <= (hwdata[7:0] & DS_WMASK) | DS_RESET;
        ADDR_IRQ_EN: keyscan_irq_enable_q <= hwdata[0];
        ADDR_GP_OUT: gp_out_q <= {hwdata[27:0], gp_out_q[15:0]};
        ADDR_STATUS: gp_out_q <= {gp_out_q[43:16], hwdata[15:0]};
        default: gp_out_q <= gp_out_q;
      endcase
    end
  end

  // Writes to any of the three control registers restart the scan.
  assign scan_restart = wr_pend_q && !addr_q[8]
    && (addr_q[7:0] == ADDR_DIGIT_CTRL || addr_q[7:0] == ADDR_SEG_CTRL
    || addr_q[7:0] == ADDR_DIGIT_START);
  assign run = digit_start_reg_q[DS_RUN_BIT];

  // Shared pin split: start code n (0..7) gives digits n..15 and segments
  // (8-n)..27; a code with its top bit set makes all eight shared pins
  // segments.
  always_comb
  begin
    if (digit_start_reg_q[3])
    begin
      first_digit = 4'h8;
    end
    else
    begin
      first_digit = {1'b0, digit_start_reg_q[2:0]};
    end
    // Shared pin k is digit k or segment 7-k.
    last_seg = segment_control_reg_q[4:0];
    last_digit = 4'hF - digit_control_reg_q[DC_RANGE_LSB +: 4];
  end

  // Enabled pins, honoring range, shared pin split and pin valid.
  always_comb
  begin
    for (int i = 0; i < 16; i++)
    begin
      dig_en[i] = (4'(i) >= first_digit) && (4'(i) <= last_digit)
        && segment_control_reg_q[SC_VALID_BIT];
    end
    for (int j = 0; j < 28; j++)
    begin
      // Shared segment j (0..7) pairs with digit 7-j.
      seg_en[j] = (5'(j) <= last_seg) && segment_control_reg_q[SC_VALID_BIT]
        && (j >= SHARED_PINS || (7 - j) < int'(first_digit));
    end
  end

  assign slot_len = digit_control_reg_q[DC_SCANT_BIT] ?
    10'(SLOT_LONG - 1) : 10'(SLOT_SHORT - 1);
  assign slot_end = (slot_cnt_q == slot_len);

  // Slot sequencer: digits first..last, then an optional key-scan slot.
  always_ff @(posedge clk)
  begin
    if (!resetn || !run || scan_restart)
    begin
      slot_cnt_q <= 10'h000;
      digit_q <= 4'h0;
      key_slot_q <= 1'b0;
    end
    else if (slot_end)
    begin
      slot_cnt_q <= 10'h000;
      if (key_slot_q || (digit_q >= last_digit
          && !segment_control_reg_q[SC_KEYSCAN_BIT]))
      begin
        key_slot_q <= 1'b0;
        digit_q <= first_digit;
      end
      else if (digit_q >= last_digit)
      begin
        key_slot_q <= 1'b1;
      end
      else
      begin
        digit_q <= digit_q + 4'h1;
      end
    end
    else
    begin
      slot_cnt_q <= slot_cnt_q + 10'h001;
    end
  end

  // Key-scan request flag: set wins over a software clear.
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      keyscan_irq_flag_q <= 1'b0;
    end
    else if (run && !scan_restart && slot_end && !key_slot_q
      && digit_q >= last_digit && segment_control_reg_q[SC_KEYSCAN_BIT])
    begin
      keyscan_irq_flag_q <= 1'b1;
    end
    else if (wr_pend_q && !addr_q[8] && addr_q[7:0] == ADDR_IRQ_REQ
      && !hwdata[0])
    begin
      keyscan_irq_flag_q <= 1'b0;
    end
  end

  // Display RAM holds segment words; unused words remain ordinary RAM.
  vfdsc_ram #(.WORDS(RAM_WORDS)) u_ram (
    .clk(clk),
    .we(ram_we),
    .waddr(addr_q[5:2]),
    .wdata(hwdata),
    .raddr(haddr[5:2]),
    .rdata(ram_rdata),
    .saddr(digit_q),
    .sdata(scan_word)
  );

  // A RAM write that lands on the edge of a read's address phase is not yet
  // seen by the registered read port, so its data are forwarded instead.
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      fwd_q <= 1'b0;
      fwd_data_q <= 32'h0000_0000;
    end
    else
    begin
      fwd_q <= ram_we && (addr_q[5:2] == haddr[5:2]);
      fwd_data_q <= hwdata;
    end
  end

  // Read mux; RAM data comes back registered in the data phase.
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      hrdata <= 32'h0000_0000;
    end
    else
    begin
      hrdata <= 32'h0000_0000;
      if (rd_pend_q && addr_q[8])
      begin
        hrdata <= fwd_q ? fwd_data_q : ram_rdata;
      end
      else if (rd_pend_q)
      begin
        unique case (addr_q[7:0])
          ADDR_DIGIT_CTRL: hrdata <= {24'h0, digit_control_reg_q};
          ADDR_SEG_CTRL: hrdata <= {24'h0, segment_control_reg_q};
          ADDR_DIGIT_START: hrdata <= {24'h0, digit_start_reg_q};
          ADDR_IRQ_REQ: hrdata <= {31'h0, keyscan_irq_flag_q};
          ADDR_IRQ_EN: hrdata <= {31'h0, keyscan_irq_enable_q};
          ADDR_GP_OUT: hrdata <= {4'h0, gp_out_q[43:16]};
          ADDR_STATUS: hrdata <= {11'h0, key_slot_q, digit_q, gp_out_q[15:0]};
          default: hrdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Pin drive runs one clock behind the scan, as the RAM read does, so a
  // strobe never shows the previous digit's pattern.
  always_ff @(posedge clk)
  begin
    if (!resetn || !run)
    begin
      segment_pin <= '0;
      digit_pin <= '0;
      segment_gp_oe <= '0;
      digit_gp_oe <= '0;
      keyscan_irq <= 1'b0;
      show_digit_q <= 4'h0;
      show_key_q <= 1'b0;
    end
    else
    begin
      keyscan_irq <= keyscan_irq_flag_q && keyscan_irq_enable_q;
      show_digit_q <= digit_q;
      show_key_q <= key_slot_q;
      if (show_key_q)
      begin
        digit_pin <= '0;
        segment_pin <= gp_out_q[43:16] & seg_en;
        segment_gp_oe <= seg_en;
        digit_gp_oe <= dig_en;
      end
      else
      begin
        segment_gp_oe <= '0;
        digit_gp_oe <= '0;
        for (int k = 0; k < 16; k++)
        begin
          digit_pin[k] <= dig_en[k] && (show_digit_q == 4'(k));
        end
        segment_pin <= digit_start_reg_q[DS_DISPLAY_ON_BIT] ?
          (scan_word[27:0] & seg_en) : 28'h0;
      end
    end
  end
endmodule : vfdsc_top

// File: tb/tb.sv
// Self-checking bench for the fluorescent display scan controller.
`timescale 1ns/1ns
module tb;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata, d;
  logic hreadyout, hresp, keyscan_irq, rd_ph = 1'b0;
  logic [27:0] segment_pin, segment_gp_oe, key_seg, gpv;
  logic [15:0] digit_pin, digit_gp_oe;
  logic [27:0] lit [16];
  logic [27:0] pat [16];
  logic [63:0] exp_q [$];
  logic [63:0] ent;
  int slots, s0, failures = 0, comparisons = 0, cyc = 0;
  vfdsc_top #(.SLOT_SHORT(4), .SLOT_LONG(8)) uut (.clk(clk),
    .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .segment_pin(segment_pin), .digit_pin(digit_pin),
    .segment_gp_oe(segment_gp_oe), .digit_gp_oe(digit_gp_oe),
    .keyscan_irq(keyscan_irq));
  vfdsc_tube tube (.clk(clk), .segment_pin(segment_pin),
    .digit_pin(digit_pin), .segment_gp_oe(segment_gp_oe),
    .digit_gp_oe(digit_gp_oe), .lit(lit), .key_seg(key_seg), .slots(slots));
  always #25 clk = ~clk;
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    comparisons++;
    if (seen !== want)
    begin
      failures++;
      $display("MISMATCH t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask : check
  task automatic conclude();
    $display("comparisons=%0d failures=%0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : conclude
  // Single transfer; each phase is held until hready is seen high.
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] v);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= a;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= v;
    do @(posedge clk); while (hreadyout !== 1'b1);
  endtask : bus
  task automatic rd(input logic [31:0] a, e, m);
    exp_q.push_back({m, e & m});
    bus(1'b0, a, $urandom);
  endtask : rd
  // Read data is taken at the end of its data phase, oldest note first.
  always @(posedge clk)
  begin
    if (rd_ph && hreadyout === 1'b1)
    begin
      ent = exp_q.pop_front();
      check(hrdata & ent[63:32], ent[31:0]);
    end
    // A data phase stretched by wait states keeps its note pending.
    if (!rd_ph || hreadyout === 1'b1)
      rd_ph <= hsel && htrans[1] && !hwrite && hreadyout;
  end
  // A hang is cut short well past the expected run length.
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      failures++;
      conclude();
    end
  end
  // Registers are set up in the order software must follow.
  initial
  begin
    void'($urandom(88018));
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    rd(32'h08, 32'h20, 32'hFF);
    rd(32'h0C, 32'h0, 32'h1);
    for (int n = 0; n < 16; n++)
    begin
      d = $urandom;
      pat[n] = d[27:0];
      bus(1'b1, 32'h100 + 4 * n, d);
      rd(32'h100 + 4 * n, d, 32'hFFFFFFFF);
    end
    bus(1'b1, 32'h00, 32'hF0);
    rd(32'h00, 32'hF0, 32'hFF);
    bus(1'b1, 32'h04, 32'h9B);
    bus(1'b1, 32'h08, 32'hC3);
    repeat (400) @(posedge clk);
    for (int n = 0; n < 16; n++)
      check(lit[n], n < 3 ? 28'h0 : pat[n] & 28'hFFFFFE0);
    s0 = slots;
    bus(1'b1, 32'h08, 32'h83);
    repeat (200) @(posedge clk);
    check(lit[9], 28'h0);
    check(slots > s0 + 5, 1'b1);
    gpv = 28'($urandom);
    bus(1'b1, 32'h04, 32'h1B);
    bus(1'b1, 32'h14, gpv);
    bus(1'b1, 32'h10, 32'h1);
    bus(1'b1, 32'h00, 32'hF0);
    repeat (8) @(posedge clk);
    bus(1'b1, 32'h04, 32'hBB);
    bus(1'b1, 32'h08, 32'hC3);
    rd(32'h18, 32'h0, 32'h100000);
    repeat (400) @(posedge clk);
    check(keyscan_irq, 1'b1);
    rd(32'h0C, 32'h1, 32'h1);
    check(key_seg, gpv & 28'hFFFFFE0);
    check(hresp, 1'b0);
    bus(1'b1, 32'h10, 32'h0);
    repeat (3) @(posedge clk);
    check(keyscan_irq, 1'b0);
    bus(1'b1, 32'h04, 32'h9B);
    bus(1'b1, 32'h0C, 32'h0);
    rd(32'h0C, 32'h0, 32'h1);
    bus(1'b1, 32'h1C, $urandom);
    rd(32'h1C, 32'h0, 32'hFFFFFFFF);
    bus(1'b1, 32'h08, 32'h43);
    repeat (4) @(posedge clk);
    check(digit_pin, 16'h0);
    rd(32'h08, 32'h63, 32'hFF);
    repeat (2) @(posedge clk);
    conclude();
  end
endmodule : tb
bind vfdsc_top vfdsc_properties chk (.clk(clk), .resetn(resetn),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hwdata(hwdata), .hready(hready), .segment_pin(segment_pin),
  .digit_pin(digit_pin), .segment_gp_oe(segment_gp_oe),
  .digit_gp_oe(digit_gp_oe), .keyscan_irq(keyscan_irq));

// File: tb/vfdsc_properties.sv
// Port checks for the fluorescent display scan controller.
`timescale 1ns/1ns
module vfdsc_properties (
  input wire logic clk,
  input wire logic resetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [27:0] segment_pin,
  input wire logic [15:0] digit_pin,
  input wire logic [27:0] segment_gp_oe,
  input wire logic [15:0] digit_gp_oe,
  input wire logic keyscan_irq
);
  logic wv_q;
  logic [31:0] wa_q;
  logic run_q, display_on_q, en_q, clr;
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  // Remember the write address so its data phase can be decoded.
  always_ff @(posedge clk)
  begin
    wv_q <= resetn && hsel && hready && htrans[1] && hwrite;
    wa_q <= haddr;
  end
  // Mirror the run, display and enable bits that the checks depend on.
  always_ff @(posedge clk)
  begin
    if (!resetn)
      {run_q, display_on_q, en_q} <= 3'h0;
    else if (wv_q && wa_q == 32'h8)
      {run_q, display_on_q} <= hwdata[7:6];
    else if (wv_q && wa_q == 32'h10)
      en_q <= hwdata[0];
  end
  assign clr = wv_q && wa_q == 32'hC;
  one_digit_a: assert property ($onehot0(digit_pin))
    else $error("two digits strobed");
  key_dark_a: assert property (|digit_gp_oe |-> digit_pin == 16'h0)
    else $error("digit lit in key slot");
  port_slot_a: assert property (|segment_gp_oe |-> digit_pin == 16'h0)
    else $error("port mode outside key slot");
  stop_dark_a: assert property (!run_q [*3] |->
    digit_pin == 16'h0 && segment_pin == 28'h0)
    else $error("pins active while stopped");
  blank_off_a: assert property (!display_on_q [*3] |->
    (segment_pin & ~segment_gp_oe) == 28'h0)
    else $error("segment lit with display off");
  irq_gate_a: assert property (keyscan_irq |-> $past(en_q))
    else $error("request forwarded while masked");
  irq_raise_a: assert property ($rose(|digit_gp_oe) && en_q
    |-> ##[0:3] keyscan_irq)
    else $error("key slot raised no request");
  irq_hold_a: assert property (keyscan_irq && en_q && $past(en_q)
    && !clr && !$past(clr) && run_q |=> keyscan_irq)
    else $error("request flag lost");
  cover property ($rose(keyscan_irq));
  cover property (digit_pin[15]);
  cover property (|segment_gp_oe);
endmodule : vfdsc_properties

// File: tb/vfdsc_tube.sv
// Behavioural tube: notes what each grid shows and how often grids switch.
`timescale 1ns/1ns
module vfdsc_tube (
  input wire logic clk,
  input wire logic [27:0] segment_pin,
  input wire logic [15:0] digit_pin,
  input wire logic [27:0] segment_gp_oe,
  input wire logic [15:0] digit_gp_oe,
  output logic [27:0] lit [16],
  output logic [27:0] key_seg,
  output int slots
);
  logic [15:0] last_q = 16'h0;
  initial
  begin
    foreach (lit[i]) lit[i] = 28'h0;
    key_seg = 28'h0;
    slots = 0;
  end
  // A grid glows with the segments driven while it is strobed.
  always @(posedge clk)
  begin
    foreach (lit[i]) if (digit_pin[i]) lit[i] <= segment_pin;
    if (digit_pin != last_q && digit_pin != 16'h0) slots <= slots + 1;
    if (|digit_gp_oe) key_seg <= segment_pin & segment_gp_oe;
    last_q <= digit_pin;
  end
endmodule : vfdsc_tube
